//--- rtl/tmr_pkg.sv
// package: register map, field layout and carrier types of the timer0 start/stop block
package tmr_pkg;

  // register offsets on the host register port
  localparam logic [7:0] TMR_ADDR_RUN_CONTROL = 8'h0E;
  localparam logic [7:0] TMR_ADDR_SETUP       = 8'h0F;
  localparam logic [7:0] TMR_ADDR_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] TMR_ADDR_RELOAD_LOW  = 8'h11;
  localparam logic [7:0] TMR_ADDR_COUNT_HIGH  = 8'h12;
  localparam logic [7:0] TMR_ADDR_COUNT_LOW   = 8'h13;

  // field positions
  localparam int TMR_NUM_TIMERS      = 4;
  localparam int TMR_ACTIVE_LSB      = 4;
  localparam int TMR_MASK_LSB        = 0;
  localparam int TMR_SETUP_HALT_BIT  = 7;
  localparam int TMR_SETUP_LAUNCH_LSB = 4;
  localparam int TMR_SETUP_RELOAD_BIT = 3;
  localparam int TMR_SETUP_TICK_LSB  = 0;

  // auto_launch_select codes
  localparam logic [1:0] TMR_LAUNCH_NEVER   = 2'h0;
  localparam logic [1:0] TMR_LAUNCH_TX_END  = 2'h1;
  localparam logic [1:0] TMR_LAUNCH_LFO     = 2'h2;
  localparam logic [1:0] TMR_LAUNCH_LFO_UF  = 2'h3;

  // tick_source_select codes
  localparam logic [1:0] TMR_TICK_FAST      = 2'h0;
  localparam logic [1:0] TMR_TICK_SLOW      = 2'h1;
  localparam logic [1:0] TMR_TICK_TIMER2    = 2'h2;
  localparam logic [1:0] TMR_TICK_TIMER1    = 2'h3;

  // reset values
  localparam logic [3:0] TMR_ACTIVE_RESET   = 4'h0;
  localparam logic [7:0] TMR_BYTE_RESET     = 8'h00;

  typedef struct packed {
    logic       halt_on_first_rx_bits;
    logic [1:0] auto_launch_select;
    logic       reload_at_zero;
    logic [1:0] tick_source_select;
  } tmr_setup_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr_req_type;

  typedef struct packed {
    logic fast;
    logic slow;
    logic timer1_underflow;
    logic timer2_underflow;
  } tmr_ticks_type;

  typedef struct packed {
    logic tx_end;
    logic rx_first_bits;
  } tmr_frame_type;

endpackage

//--- rtl/tmr_timer0.sv
// timer section: shared start/stop register and the complete first down-counting timer
//
// How it works
// - masked write updates only selected running bits
// - mask bit n steers running bit n+4
// - running bit reads state; write starts/stops
// - halt bit stops timer0 after 4 rx bits
// - halt bit ignored in oscillator trimming modes
// - launch 00 never, 01 at transmission end
// - launch 10/11 trimming, start/stop on rising edges
// - reload bit set, launch other than 10: reload and continue at zero
// - reload bit clear, launch other than 10: stop at zero, clear running
// - every underflow sets the irq flag
// - tick select 00 fast, 01 slow
// - tick select 10 timer2, 11 timer1 underflow
// - start loads counter from 16-bit reload word
// - reload writes affect only next start or next reload at zero
// - low reload byte readable and writable register
// - count bytes readable; host avoids reading mid-reception
`timescale 1ns/1ps
module tmr_timer0 #(
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire tmr_pkg::tmr_req_type   req,
  input  wire tmr_pkg::tmr_ticks_type ticks,
  input  wire tmr_pkg::tmr_frame_type frame,
  input  wire logic               lfo_pin,
  input  wire logic [2:0]         other_timer_done,
  input  wire logic               irq_clear,
  output logic [7:0]              rdata,
  output logic [3:0]              timer_active,
  output logic                    underflow,
  output logic                    timer_underflow_irq_flag
);

  // the count bytes and the reload word assume a counter of at most 16 bits
  if (COUNT_WIDTH < 9 || COUNT_WIDTH > 16) begin : g_bad_width
    $error("COUNT_WIDTH must lie between 9 and 16");
  end

  // register state
  tmr_pkg::tmr_setup_type setup_q, setup_d;
  logic [7:0]             reload_high_q, reload_high_d;
  logic [7:0]             reload_low_q, reload_low_d;
  logic [3:0]             active_q, active_d;
  logic [COUNT_WIDTH-1:0] count_q, count_d;
  logic                   underflow_q, underflow_d;
  logic                   irq_q, irq_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   lfo_meta_q, lfo_sync_q, lfo_last_q;

  // decoded helpers
  logic                   wr_run;
  logic                   lfo_mode;
  logic                   lfo_edge;
  logic                   tick;
  logic                   start;
  logic [15:0]            reload_word;
  logic [15:0]            count16;

  assign reload_word = {reload_high_q, reload_low_q};
  assign count16     = 16'(count_q);
  assign wr_run      = req.wr && (req.addr == tmr_pkg::TMR_ADDR_RUN_CONTROL);
  assign lfo_mode    = setup_q.auto_launch_select[1];
  // only the second and third stages are compared; the first may be metastable
  assign lfo_edge    = lfo_sync_q && !lfo_last_q;

  always_comb begin
    case (setup_q.tick_source_select)
      tmr_pkg::TMR_TICK_FAST:   tick = ticks.fast;
      tmr_pkg::TMR_TICK_SLOW:   tick = ticks.slow;
      tmr_pkg::TMR_TICK_TIMER2: tick = ticks.timer2_underflow;
      default:                  tick = ticks.timer1_underflow;
    endcase
  end

  // pin synchroniser for the trimming reference
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lfo_meta_q <= 1'b0;
      lfo_sync_q <= 1'b0;
      lfo_last_q <= 1'b0;
    end else begin
      lfo_meta_q <= lfo_pin;
      lfo_sync_q <= lfo_meta_q;
      lfo_last_q <= lfo_sync_q;
    end
  end

  // counter, running bits and events
  always_comb begin
    active_d    = active_q;
    count_d     = count_q;
    underflow_d = 1'b0;
    start       = 1'b0;
    for (int i = 1; i < tmr_pkg::TMR_NUM_TIMERS; i++) begin
      if (other_timer_done[i-1]) begin
        active_d[i] = 1'b0;
      end
    end
    if (active_q[0]) begin
      if (tick) begin
        if (count_q == '0) begin
          // trimming without underflow parks at zero
          if (setup_q.auto_launch_select != tmr_pkg::TMR_LAUNCH_LFO) begin
            underflow_d = 1'b1;
            if (setup_q.reload_at_zero) begin
              count_d = COUNT_WIDTH'(reload_word);
            end else begin
              active_d[0] = 1'b0;
            end
          end
        end else begin
          count_d = count_q - COUNT_WIDTH'(1);
        end
      end
      if (setup_q.halt_on_first_rx_bits && !lfo_mode && frame.rx_first_bits) begin
        active_d[0] = 1'b0;
      end
      if (lfo_mode && lfo_edge) begin
        active_d[0] = 1'b0;
      end
    end else begin
      if (setup_q.auto_launch_select == tmr_pkg::TMR_LAUNCH_TX_END && frame.tx_end) begin
        start = 1'b1;
      end
      if (lfo_mode && lfo_edge) begin
        start = 1'b1;
      end
    end
    // host write comes last so it overrides hardware events in the same cycle
    if (wr_run) begin
      for (int i = 0; i < tmr_pkg::TMR_NUM_TIMERS; i++) begin
        if (req.wdata[tmr_pkg::TMR_MASK_LSB + i]) begin
          active_d[i] = req.wdata[tmr_pkg::TMR_ACTIVE_LSB + i];
        end
      end
      if (req.wdata[tmr_pkg::TMR_MASK_LSB]) begin
        start = req.wdata[tmr_pkg::TMR_ACTIVE_LSB];
      end
    end
    if (start) begin
      active_d[0] = 1'b1;
      count_d     = COUNT_WIDTH'(reload_word);
    end
  end

  // sticky flag: a new underflow wins over a clear in the same cycle
  always_comb begin
    if (underflow_d) begin
      irq_d = 1'b1;
    end else if (irq_clear) begin
      irq_d = 1'b0;
    end else begin
      irq_d = irq_q;
    end
  end

  // host register writes and reads
  always_comb begin
    setup_d       = setup_q;
    reload_high_d = reload_high_q;
    reload_low_d  = reload_low_q;
    rdata_d       = rdata_q;
    if (req.wr) begin
      if (req.addr == tmr_pkg::TMR_ADDR_SETUP) begin
        setup_d.halt_on_first_rx_bits = req.wdata[tmr_pkg::TMR_SETUP_HALT_BIT];
        setup_d.auto_launch_select    = req.wdata[tmr_pkg::TMR_SETUP_LAUNCH_LSB +: 2];
        setup_d.reload_at_zero        = req.wdata[tmr_pkg::TMR_SETUP_RELOAD_BIT];
        setup_d.tick_source_select    = req.wdata[tmr_pkg::TMR_SETUP_TICK_LSB +: 2];
      end else if (req.addr == tmr_pkg::TMR_ADDR_RELOAD_HIGH) begin
        reload_high_d = req.wdata;
      end else if (req.addr == tmr_pkg::TMR_ADDR_RELOAD_LOW) begin
        reload_low_d = req.wdata;
      end
    end
    if (req.rd) begin
      if (req.addr == tmr_pkg::TMR_ADDR_RUN_CONTROL) begin
        rdata_d = {active_q, 4'h0};
      end else if (req.addr == tmr_pkg::TMR_ADDR_SETUP) begin
        rdata_d = {setup_q.halt_on_first_rx_bits, 1'b0, setup_q.auto_launch_select,
                   setup_q.reload_at_zero, 1'b0, setup_q.tick_source_select};
      end else if (req.addr == tmr_pkg::TMR_ADDR_RELOAD_HIGH) begin
        rdata_d = reload_high_q;
      end else if (req.addr == tmr_pkg::TMR_ADDR_RELOAD_LOW) begin
        rdata_d = reload_low_q;
      end else if (req.addr == tmr_pkg::TMR_ADDR_COUNT_HIGH) begin
        rdata_d = count16[15:8];
      end else if (req.addr == tmr_pkg::TMR_ADDR_COUNT_LOW) begin
        rdata_d = count16[7:0];
      end else begin
        rdata_d = tmr_pkg::TMR_BYTE_RESET;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      setup_q       <= '0;
      reload_high_q <= tmr_pkg::TMR_BYTE_RESET;
      reload_low_q  <= tmr_pkg::TMR_BYTE_RESET;
      active_q      <= tmr_pkg::TMR_ACTIVE_RESET;
      count_q       <= '0;
      underflow_q   <= 1'b0;
      irq_q         <= 1'b0;
      rdata_q       <= tmr_pkg::TMR_BYTE_RESET;
    end else begin
      setup_q       <= setup_d;
      reload_high_q <= reload_high_d;
      reload_low_q  <= reload_low_d;
      active_q      <= active_d;
      count_q       <= count_d;
      underflow_q   <= underflow_d;
      irq_q         <= irq_d;
      rdata_q       <= rdata_d;
    end
  end

  assign rdata                    = rdata_q;
  assign timer_active             = active_q;
  assign underflow                = underflow_q;
  assign timer_underflow_irq_flag = irq_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_zero_tick;
    active_q[0] && tick && count_q == '0 && !wr_run &&
      setup_q.auto_launch_select != tmr_pkg::TMR_LAUNCH_LFO &&
      !(setup_q.halt_on_first_rx_bits && !lfo_mode && frame.rx_first_bits) &&
      !(lfo_mode && lfo_edge);
  endsequence

  a_mask_blocks_bit: assert property (
    wr_run && !req.wdata[1] && !other_timer_done[0] |=> active_q[1] == $past(active_q[1]))
    else $error("unmasked running bit changed on write");

  a_mask_steers_bit: assert property (
    wr_run && req.wdata[2] |=> active_q[2] == $past(req.wdata[6]))
    else $error("masked running bit not taken from bit n+4");

  a_write_start_load: assert property (
    wr_run && req.wdata[0] && req.wdata[4] |=> active_q[0] && count16 == $past(reload_word))
    else $error("write start did not load reload word");

  a_rx_halt_stop: assert property (
    active_q[0] && setup_q.halt_on_first_rx_bits && !lfo_mode && frame.rx_first_bits && !wr_run
      |=> !active_q[0])
    else $error("timer kept running after first rx bits");

  a_trim_ignores_rx: assert property (
    active_q[0] && lfo_mode && frame.rx_first_bits && !lfo_edge && !wr_run && !tick |=> active_q[0])
    else $error("trimming mode stopped on receive");

  a_trim_edge_start: assert property (
    !active_q[0] && lfo_mode && lfo_edge && !wr_run |=> active_q[0] && count16 == $past(reload_word))
    else $error("rising trim edge did not start the timer");

  a_trim_edge_stop: assert property (
    active_q[0] && lfo_mode && lfo_edge && !wr_run |=> !active_q[0])
    else $error("rising trim edge did not stop the timer");

  a_tx_end_start: assert property (
    !active_q[0] && setup_q.auto_launch_select == tmr_pkg::TMR_LAUNCH_TX_END && frame.tx_end && !wr_run
      |=> active_q[0] && count16 == $past(reload_word))
    else $error("no start at end of transmission");

  a_never_self_start: assert property (
    !active_q[0] && setup_q.auto_launch_select == tmr_pkg::TMR_LAUNCH_NEVER && !wr_run |=> !active_q[0])
    else $error("timer started by itself");

  a_reload_continue: assert property (
    s_zero_tick and setup_q.reload_at_zero |=> active_q[0] && count16 == $past(reload_word))
    else $error("no reload at zero");

  a_stop_at_zero: assert property (
    s_zero_tick and !setup_q.reload_at_zero |=> !active_q[0] ##1 !active_q[0] || $past(start))
    else $error("timer did not stop at zero");

  a_irq_follows_uf: assert property (
    s_zero_tick |=> underflow_q && timer_underflow_irq_flag)
    else $error("underflow did not raise the flag");

  a_tick_decrement: assert property (
    active_q[0] && tick && count_q != '0 && !wr_run && !(lfo_mode && lfo_edge)
      |=> count_q == $past(count_q) - COUNT_WIDTH'(1))
    else $error("counter did not step down on tick");

  a_reload_undisturbed: assert property (
    active_q[0] && !tick && req.wr && req.addr == tmr_pkg::TMR_ADDR_RELOAD_LOW |=> count_q == $past(count_q))
    else $error("reload write disturbed running count");

  a_uf_single_pulse: assert property (
    underflow_q && !tick |=> !underflow_q)
    else $error("underflow pulse longer than one cycle");

endmodule // tmr_timer0

//--- verif/tb_top.sv
// testbench: timer0 block driven at its ports, checked each cycle against a behavioural model
`timescale 1ns/1ps
module tb_top;
  logic                   clock;
  logic                   arst_n;
  tmr_pkg::tmr_req_type   req;
  tmr_pkg::tmr_ticks_type ticks;
  tmr_pkg::tmr_frame_type frame;
  logic                   lfo_pin;
  logic [2:0]             other_timer_done;
  logic                   irq_clear;
  logic [7:0]             rdata;
  logic [3:0]             timer_active;
  logic                   underflow;
  logic                   timer_underflow_irq_flag;
  logic [15:0]            lfsr_q;
  int                     n_mismatch;
  int                     n_compared;
  int                     m_cnt, m_act, m_uf, m_flag, m_rd, m_setup, m_rlh, m_rll;

  tmr_timer0 tmr_timer0_i (.clock(clock), .arst_n(arst_n), .req(req), .ticks(ticks), .frame(frame),
    .lfo_pin(lfo_pin), .other_timer_done(other_timer_done), .irq_clear(irq_clear), .rdata(rdata),
    .timer_active(timer_active), .underflow(underflow), .timer_underflow_irq_flag(timer_underflow_irq_flag));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // model sees the same pre-edge inputs as the design; stop keeps the count where it was
  always @(posedge clock or negedge arst_n) begin : model_b
    int rl, tk, lau, was_on, hw_start, trim_edge, p1, p2, p3;
    if (!arst_n) begin
      m_cnt = 0; m_act = 0; m_uf = 0; m_flag = 0; m_rd = 0; m_setup = 0; m_rlh = 0; m_rll = 0;
      p1 = 0; p2 = 0; p3 = 0;
    end else begin
      rl = m_rlh * 256 + m_rll;
      lau = (m_setup >> 4) & 3;
      was_on = m_act & 1;
      // the trim pin passes two stages before its rising edge counts
      trim_edge = p2 && !p3;
      p3 = p2;
      p2 = p1;
      p1 = lfo_pin;
      hw_start = !was_on && ((lau == 1 && frame.tx_end) || (lau >= 2 && trim_edge));
      case (m_setup & 3)
        0: tk = ticks.fast;
        1: tk = ticks.slow;
        2: tk = ticks.timer2_underflow;
        default: tk = ticks.timer1_underflow;
      endcase
      m_uf = 0;
      if (req.rd) begin
        case (req.addr)
          8'h0E: m_rd = (m_act & 15) << 4;
          8'h0F: m_rd = m_setup;
          8'h10: m_rd = m_rlh;
          8'h11: m_rd = m_rll;
          8'h12: m_rd = m_cnt >> 8;
          8'h13: m_rd = m_cnt & 255;
          default: m_rd = 0;
        endcase
      end
      if (irq_clear) m_flag = 0;
      if ((m_act & 1) && tk) begin
        if (m_cnt > 0) m_cnt--;
        else if (lau != 2) begin
          m_uf = 1; m_flag = 1;
          if (m_setup & 8) m_cnt = rl;
          else m_act &= 14;
        end
      end
      if (frame.rx_first_bits && (m_setup & 128) && lau < 2) m_act &= 14;
      if (was_on && lau >= 2 && trim_edge) m_act &= 14;
      m_act &= ~(int'(other_timer_done) << 1);
      if (req.wr) begin
        case (req.addr)
          8'h0E: for (int n = 0; n < 4; n++) if (req.wdata[n]) begin
            if (req.wdata[n+4]) m_act |= 1 << n;
            else m_act &= ~(1 << n);
            // the host's start/stop wins over a hardware start in the same cycle
            if (n == 0) hw_start = req.wdata[4];
          end
          8'h0F: m_setup = req.wdata & 8'hBB;
          8'h10: m_rlh = req.wdata;
          8'h11: m_rll = req.wdata;
          default: ;
        endcase
      end
      if (hw_start) begin
        m_act |= 1;
        m_cnt = rl;
      end
    end
  end

  always @(negedge clock) begin
    if (arst_n) begin
      n_compared++;
      if (timer_active !== 4'(m_act) || underflow !== 1'(m_uf) || timer_underflow_irq_flag !== 1'(m_flag) ||
          rdata !== 8'(m_rd)) begin
        n_mismatch++;
        $display("[ERR] %0t active %h uf %b flag %b rdata %h", $time, timer_active, underflow,
                 timer_underflow_irq_flag, rdata);
      end
    end
  end

  // every input but clock, arst_n and lfo_pin is assigned exactly once per cycle, so back-to-back calls never collide
  task automatic step(input logic [17:0] r, input logic [3:0] tk, input logic [1:0] fr, input logic [2:0] od,
                      input logic ic);
    req <= r;
    ticks <= tk;
    frame <= fr;
    other_timer_done <= od;
    irq_clear <= ic;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step({2'b10, a, d}, 4'h0, 2'h0, 3'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    step({2'b01, a, 8'h00}, 4'h0, 2'h0, 3'h0, 1'b0);
  endtask

  task automatic idle(input logic [3:0] tk, input logic [1:0] fr, input int n);
    repeat (n) step(18'h0, tk, fr, 3'h0, 1'b0);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end

  initial begin
    arst_n = 1'b0; req = '0; ticks = '0; frame = '0; lfo_pin = 1'b0; other_timer_done = 3'h0; irq_clear = 1'b0;
    lfsr_q = 16'h8DE5; n_mismatch = 0; n_compared = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    for (int a = 14; a <= 20; a++) rd(8'(a));
    wr(8'h0F, 8'hFF); wr(8'h10, 8'hA5); wr(8'h11, 8'h3C); wr(8'h12, 8'h77);
    for (int a = 14; a <= 20; a++) rd(8'(a));
    $display("test registers done");
    wr(8'h0F, 8'h08); wr(8'h0E, 8'hF0); rd(8'h0E);
    for (int n = 0; n < 4; n++) begin
      wr(8'h0E, 8'hF0 | 8'(1 << n)); rd(8'h0E);
    end
    wr(8'h0E, 8'h0A); wr(8'h0E, 8'h0F); rd(8'h0E);
    $display("test write mask done");
    wr(8'h10, 8'h00); wr(8'h11, 8'h01); wr(8'h0F, 8'h00); wr(8'h0E, 8'h11);
    idle(4'h8, 2'h0, 4);
    step(18'h0, 4'h0, 2'h0, 3'h0, 1'b1); idle(4'h0, 2'h0, 1);
    wr(8'h11, 8'h02); wr(8'h0F, 8'h08); wr(8'h0E, 8'h11); wr(8'h11, 8'h05);
    idle(4'h8, 2'h0, 1); rd(8'h13); rd(8'h12); wr(8'h11, 8'h02);
    idle(4'h8, 2'h0, 9);
    $display("test count and reload done");
    wr(8'h0E, 8'h01); wr(8'h0F, 8'h80); idle(4'h0, 2'h2, 1); idle(4'h0, 2'h0, 1);
    wr(8'h0F, 8'h90); idle(4'h0, 2'h2, 1); idle(4'h0, 2'h1, 1); idle(4'h0, 2'h0, 1);
    wr(8'h0F, 8'h10); idle(4'h0, 2'h2, 1); idle(4'h0, 2'h1, 1); idle(4'h0, 2'h0, 1);
    wr(8'h0F, 8'hA0); wr(8'h0E, 8'h11); idle(4'h0, 2'h1, 1); rd(8'h0E);
    wr(8'h0F, 8'hB0); idle(4'h0, 2'h1, 1); rd(8'h0E);
    lfo_pin <= 1'b1; idle(4'h0, 2'h0, 4); rd(8'h0E);
    lfo_pin <= 1'b0; idle(4'h0, 2'h0, 3);
    lfo_pin <= 1'b1; idle(4'h8, 2'h0, 6); rd(8'h0E);
    wr(8'h0F, 8'h20); wr(8'h0E, 8'h11); idle(4'h8, 2'h0, 5); rd(8'h0E); rd(8'h13);
    $display("test frame events done");
    for (int q = 0; q < 4; q++) begin
      wr(8'h10, 8'h00); wr(8'h11, 8'h07); wr(8'h0F, 8'h08 | 8'(q)); wr(8'h0E, 8'hFF);
      for (int i = 0; i < 700; i++) begin
        lfsr_q = lfsr_next(lfsr_q);
        step({1'b0, lfsr_q[0], 8'h0E + 8'(lfsr_q[3:1] % 6), 8'h00}, lfsr_q[7:4], 2'h0,
             (lfsr_q[8] & lfsr_q[9]) ? lfsr_q[12:10] : 3'h0, lfsr_q[13] & lfsr_q[14]);
      end
    end
    idle(4'h0, 2'h0, 2);
    $display("test random ticks done");
    end_sim;
  end
endmodule // tb_top
